// ---- design/charge_limit_pkg.sv ----
// Purpose: Shared constants and carriers for the charge limit register bank
// Assumes: Command codes, field positions and limits as the charger defines them
// Notes: Limits are kept in mA and mV; codes are derived from them here
package charge_limit_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;

  // ==========================================================================
  // Field layout
  localparam int WORD_W = 16;
  localparam int CUR_LSB = 6;
  localparam int CUR_W = 7;
  localparam int VOLT_LSB = 4;
  localparam int VOLT_W = 11;

  // ==========================================================================
  // Legal ranges in physical units, with the codes that follow from them
  localparam int CUR_STEP_MA = 64;
  localparam int CUR_MIN_MA = 128;
  localparam int CUR_MAX_MA = 8128;
  localparam int VOLT_STEP_MV = 16;
  localparam int VOLT_MIN_MV = 1024;
  localparam int VOLT_MAX_MV = 19200;
  localparam logic [CUR_W-1:0] CUR_CODE_MIN = CUR_W'(CUR_MIN_MA / CUR_STEP_MA);
  localparam logic [CUR_W-1:0] CUR_CODE_MAX = CUR_W'(CUR_MAX_MA / CUR_STEP_MA);
  localparam logic [VOLT_W-1:0] VOLT_CODE_MIN = VOLT_W'(VOLT_MIN_MV / VOLT_STEP_MV);
  localparam logic [VOLT_W-1:0] VOLT_CODE_MAX = VOLT_W'(VOLT_MAX_MV / VOLT_STEP_MV);

  // ==========================================================================
  // Reset values and serial framing
  localparam logic [CUR_W-1:0] CUR_CODE_RESET = 7'h00;
  localparam logic [VOLT_W-1:0] VOLT_CODE_RESET = 11'h000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Arbitrary default slave address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h09;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic scl;
    logic sda;
  } smb_pins_s;

  typedef struct packed {
    logic [CUR_W-1:0] current_code;
    logic [VOLT_W-1:0] voltage_code;
    logic enable;
  } charge_ctrl_s;

endpackage

// ---- design/sync2.sv ----
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 2
) (
  input logic mclk,
  input logic resetn,
  input logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Idle bus level is high, so reset to ones
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '1;
      sync_out <= '1;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ---- design/charge_limit_registers.sv ----
// Purpose: Charge current and charge voltage limit registers behind an SMBus slave
// Assumes: mclk at 50 MHz; SMBus pins are open drain and asynchronous to mclk
// Notes: Write Word and Read Word protocols; the pin limit arrives as a 7-bit code
`timescale 1ns/1ps
module charge_limit_registers #(
  parameter logic [6:0] DEV_ADDR = charge_limit_pkg::DEV_ADDR_DEFAULT
) (
  input logic mclk,
  input logic resetn,
  input charge_limit_pkg::smb_pins_s smb_in,
  output logic sda_out,
  output logic sda_oe,
  input logic [charge_limit_pkg::CUR_W-1:0] current_limit_pin,
  output charge_limit_pkg::charge_ctrl_s charge_ctrl,
  output logic charge_stop
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } smb_state_e;

  // ==========================================================================
  // Helper functions
  function automatic logic cur_valid(input logic [charge_limit_pkg::CUR_W-1:0] code);
    cur_valid = (code >= charge_limit_pkg::CUR_CODE_MIN) && (code <= charge_limit_pkg::CUR_CODE_MAX);
  endfunction

  function automatic logic volt_valid(input logic [charge_limit_pkg::VOLT_W-1:0] code);
    volt_valid = (code >= charge_limit_pkg::VOLT_CODE_MIN) && (code <= charge_limit_pkg::VOLT_CODE_MAX);
  endfunction

  function automatic logic known_cmd(input logic [7:0] cmd);
    known_cmd = (cmd == charge_limit_pkg::CMD_CHARGE_CURRENT) || (cmd == charge_limit_pkg::CMD_CHARGE_VOLTAGE);
  endfunction

  // ==========================================================================
  // Pin synchronisation and bus event detection
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  sync2 #(
    .WIDTH(2)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in({smb_in.scl, smb_in.sda}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Delayed copies for edge detection, taken after the synchroniser
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  // Data edges while the clock is high frame a transaction
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ==========================================================================
  // Stored settings
  logic [charge_limit_pkg::CUR_W-1:0] cur_code_r;
  logic [charge_limit_pkg::VOLT_W-1:0] volt_code_r;

  // ==========================================================================
  // Serial engine
  smb_state_e state_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] cmd_r;
  logic is_read_r;
  logic ack_r;
  logic byte_idx_r;
  logic host_nack_r;
  logic [7:0] wr_low_r;
  logic wr_commit_r;
  logic [charge_limit_pkg::WORD_W-1:0] wr_word_r;
  logic [charge_limit_pkg::WORD_W-1:0] rd_word;

  // Read view: fields in place, every other bit zero
  always_comb begin
    rd_word = '0;
    if (cmd_r == charge_limit_pkg::CMD_CHARGE_CURRENT) begin
      rd_word[charge_limit_pkg::CUR_LSB +: charge_limit_pkg::CUR_W] = cur_code_r;
    end else if (cmd_r == charge_limit_pkg::CMD_CHARGE_VOLTAGE) begin
      rd_word[charge_limit_pkg::VOLT_LSB +: charge_limit_pkg::VOLT_W] = volt_code_r;
    end
  end

  // Byte framing, acknowledge decisions and word assembly
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'hFF;
      cmd_r <= 8'h00;
      is_read_r <= 1'b0;
      ack_r <= 1'b0;
      byte_idx_r <= 1'b0;
      host_nack_r <= 1'b0;
      wr_low_r <= 8'h00;
      wr_commit_r <= 1'b0;
      wr_word_r <= 16'h0000;
    end else begin
      wr_commit_r <= 1'b0;
      if (start_det) begin
        // Repeated start keeps the command for a Read Word
        state_r <= ST_ADDR;
        bitcnt_r <= 4'h0;
        ack_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        ack_r <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
          end
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise && bitcnt_r != charge_limit_pkg::BYTE_BITS) begin
              shift_r <= {shift_r[6:0], sda_s};
              bitcnt_r <= bitcnt_r + 4'h1;
            end else if (scl_fall && bitcnt_r == charge_limit_pkg::BYTE_BITS) begin
              bitcnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                ack_r <= (shift_r[7:1] == DEV_ADDR);
                is_read_r <= shift_r[0];
                state_r <= (shift_r[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              end else if (state_r == ST_CMD) begin
                cmd_r <= shift_r;
                ack_r <= known_cmd(shift_r);
                state_r <= known_cmd(shift_r) ? ST_CMD_ACK : ST_IDLE;
              end else begin
                ack_r <= 1'b1;
                state_r <= ST_WDATA_ACK;
                if (!byte_idx_r) begin
                  wr_low_r <= shift_r;
                end else begin
                  // Low byte first, high byte completes the word
                  wr_word_r <= {shift_r, wr_low_r};
                  wr_commit_r <= 1'b1;
                end
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              ack_r <= 1'b0;
              byte_idx_r <= 1'b0;
              if (is_read_r) begin
                tx_r <= rd_word[7:0];
                state_r <= ST_RDATA;
              end else begin
                state_r <= ST_CMD;
              end
            end
          end
          ST_CMD_ACK: begin
            if (scl_fall) begin
              ack_r <= 1'b0;
              byte_idx_r <= 1'b0;
              state_r <= ST_WDATA;
            end
          end
          ST_WDATA_ACK: begin
            if (scl_fall) begin
              ack_r <= 1'b0;
              // Bytes past the word are refused with a not-acknowledge
              state_r <= byte_idx_r ? ST_IDLE : ST_WDATA;
              byte_idx_r <= 1'b1;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt_r[2:0] == charge_limit_pkg::LAST_BIT) begin
                bitcnt_r <= 4'h0;
                tx_r <= 8'hFF;
                state_r <= ST_RDATA_ACK;
              end else begin
                bitcnt_r <= bitcnt_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b1};
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              host_nack_r <= sda_s;
            end else if (scl_fall) begin
              if (host_nack_r || byte_idx_r) begin
                state_r <= ST_IDLE;
              end else begin
                byte_idx_r <= 1'b1;
                tx_r <= rd_word[15:8];
                state_r <= ST_RDATA;
              end
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pull low; release while sending a one
  assign sda_out = 1'b0;
  assign sda_oe = ack_r | ((state_r == ST_RDATA) & ~tx_r[7]);

  // ==========================================================================
  // Setting registers; a bad write clears the field and ends charging
  logic [charge_limit_pkg::CUR_W-1:0] wr_cur_code;
  logic [charge_limit_pkg::VOLT_W-1:0] wr_volt_code;

  // Bits outside each field are dropped here
  assign wr_cur_code = wr_word_r[charge_limit_pkg::CUR_LSB +: charge_limit_pkg::CUR_W];
  assign wr_volt_code = wr_word_r[charge_limit_pkg::VOLT_LSB +: charge_limit_pkg::VOLT_W];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cur_code_r <= charge_limit_pkg::CUR_CODE_RESET;
    end else if (wr_commit_r && cmd_r == charge_limit_pkg::CMD_CHARGE_CURRENT) begin
      cur_code_r <= cur_valid(wr_cur_code) ? wr_cur_code : charge_limit_pkg::CUR_CODE_RESET;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      volt_code_r <= charge_limit_pkg::VOLT_CODE_RESET;
    end else if (wr_commit_r && cmd_r == charge_limit_pkg::CMD_CHARGE_VOLTAGE) begin
      volt_code_r <= volt_valid(wr_volt_code) ? wr_volt_code : charge_limit_pkg::VOLT_CODE_RESET;
    end
  end

  // One-cycle stop pulse on a rejected write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      charge_stop <= 1'b0;
    end else begin
      charge_stop <= wr_commit_r &&
        ((cmd_r == charge_limit_pkg::CMD_CHARGE_CURRENT && !cur_valid(wr_cur_code)) ||
         (cmd_r == charge_limit_pkg::CMD_CHARGE_VOLTAGE && !volt_valid(wr_volt_code)));
    end
  end

  // ==========================================================================
  // Effective limits to the regulation loop
  // The pin code saturates at full scale when the pin sits above its top level,
  // so the register alone then governs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      charge_ctrl <= '0;
    end else begin
      charge_ctrl.current_code <= (current_limit_pin < cur_code_r) ? current_limit_pin : cur_code_r;
      charge_ctrl.voltage_code <= volt_code_r;
      // A zero setting in either register means no charging
      charge_ctrl.enable <= (cur_code_r != charge_limit_pkg::CUR_CODE_RESET) &&
        (volt_code_r != charge_limit_pkg::VOLT_CODE_RESET);
    end
  end

endmodule

// ---- verif/charge_limit_monitor.sv ----
// Purpose: Port assertions for the charge limit register bank
// Assumes: The host keeps SCL low for at least 8 mclk
// Notes: Bound to every instance of the register bank
`timescale 1ns/1ps
module charge_limit_monitor (
  input logic mclk,
  input logic resetn,
  input charge_limit_pkg::smb_pins_s smb_in,
  input logic sda_out,
  input logic sda_oe,
  input logic [charge_limit_pkg::CUR_W-1:0] current_limit_pin,
  input charge_limit_pkg::charge_ctrl_s charge_ctrl,
  input logic charge_stop
);
  // ==========================================================================
  // One clock domain, so clock and disable are shared
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Open drain: only ever pulls low
  sda_drive_low_a: assert property (!sda_out) else $error("sda_out driven high");
  reset_clear_a: assert property ($rose(resetn) |-> charge_ctrl == '0 && !charge_stop)
    else $error("outputs not clear after reset");
  stop_pulse_a: assert property (charge_stop |=> !charge_stop) else $error("stop wider than one cycle");
  stop_halts_a: assert property (charge_stop |-> ##[0:2] !charge_ctrl.enable)
    else $error("charging kept on after stop");
  // Pin takes one flop to reach the output
  pin_ceiling_a: assert property (charge_ctrl.current_code <= $past(current_limit_pin))
    else $error("current above pin limit");
  volt_legal_a: assert property (charge_ctrl.voltage_code == '0 || charge_ctrl.voltage_code inside
    {[charge_limit_pkg::VOLT_CODE_MIN:charge_limit_pkg::VOLT_CODE_MAX]}) else $error("voltage code out of range");
  enable_volt_a: assert property (charge_ctrl.enable |-> charge_ctrl.voltage_code != '0)
    else $error("enabled with zero voltage");
  // Data may only move while SCL is low, else it reads as start or stop
  sda_setup_a: assert property ($changed(sda_oe) |-> !smb_in.scl)
    else $error("sda moved while scl high");
endmodule

bind charge_limit_registers charge_limit_monitor charge_limit_monitor_i (.mclk(mclk), .resetn(resetn),
  .smb_in(smb_in), .sda_out(sda_out), .sda_oe(sda_oe), .current_limit_pin(current_limit_pin),
  .charge_ctrl(charge_ctrl), .charge_stop(charge_stop));

// ---- verif/smb_host_model.sv ----
// Purpose: Behavioural SMBus host for the charge limit registers
// Assumes: SDA has a pull-up; the device only pulls it low
// Notes: SCL stands high between frames; half period 8 mclk
`timescale 1ns/1ps
module smb_host_model #(
  parameter logic [6:0] ADDR = charge_limit_pkg::DEV_ADDR_DEFAULT
) (
  input logic mclk,
  input logic sda_oe,
  output charge_limit_pkg::smb_pins_s pins
);
  logic scl_r = 1'b1;
  logic sda_drv_r = 1'b1;
  // Address sent in the first byte; the bench may point it elsewhere to test refusal
  logic [6:0] addr_r = ADDR;
  logic [15:0] rd_word;
  logic rd_ok;
  event rd_ev;
  // ==========================================================================
  // Wired-AND of both parties on the open-drain line
  assign pins = '{scl: scl_r, sda: sda_drv_r & ~sda_oe};

  task automatic hp;
    repeat (8) @(negedge mclk);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start;
    sda_drv_r = 1'b1;
    hp;
    scl_r = 1'b1;
    hp;
    sda_drv_r = 1'b0;
    hp;
    scl_r = 1'b0;
  endtask
  task automatic stop;
    hp;
    sda_drv_r = 1'b0;
    hp;
    scl_r = 1'b1;
    hp;
    sda_drv_r = 1'b1;
  endtask
  // Nine bits MSB first; SDA moves a half period after SCL falls
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hp;
      sda_drv_r = tx[i];
      hp;
      scl_r = 1'b1;
      hp;
      rx[i] = pins.sda;
      scl_r = 1'b0;
    end
  endtask
  // Low byte before high byte
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
    logic [8:0] a, c, l, h;
    start;
    xfer({addr_r, 2'b01}, a);
    xfer({cmd, 1'b1}, c);
    xfer({d[7:0], 1'b1}, l);
    xfer({d[15:8], 1'b1}, h);
    stop;
    ok = !(a[0] | c[0] | l[0] | h[0]);
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
    logic [8:0] a, c, r, l, h;
    start;
    xfer({addr_r, 2'b01}, a);
    xfer({cmd, 1'b1}, c);
    start;
    xfer({addr_r, 2'b11}, r);
    xfer(9'h1FE, l);
    xfer(9'h1FF, h);
    stop;
    d = {h[8:1], l[8:1]};
    ok = !(a[0] | c[0] | r[0]);
    rd_word = d;
    rd_ok = ok;
    ->rd_ev;
  endtask
endmodule

// ---- verif/charge_limit_registers_bench.sv ----
// Purpose: Self-checking bench for the charge limit registers
// Assumes: Host model drives SMBus; bench drives reset and pin at falling edges
// Notes: Expected read words are queued and compared in order by a watcher
`timescale 1ns/1ps
module charge_limit_registers_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] current_limit_pin = 7'h7F;
  logic sda_out, sda_oe, charge_stop, ok;
  charge_limit_pkg::smb_pins_s pins;
  charge_limit_pkg::charge_ctrl_s ctrl;
  int err_count = 0;
  int n_compared = 0;
  int stops = 0;
  int exp_stops = 0;
  int seed = 32'h5141;
  logic [15:0] notes_q[$];
  logic [15:0] rd;
  logic [6:0] cur = 7'h00;
  logic [10:0] volt = 11'h000;
  localparam logic [23:0] VEC [11] = '{24'h14FFC0, 24'h150400, 24'h140040, 24'h140080, 24'h154B10,
    24'h15CB0F, 24'h1503F0, 24'h157FF0, 24'h154B00, 24'h140000, 24'h140FC0};

  always #10 mclk = ~mclk;

  charge_limit_registers charge_limit_registers_i (.mclk(mclk), .resetn(resetn), .smb_in(pins),
    .sda_out(sda_out), .sda_oe(sda_oe), .current_limit_pin(current_limit_pin), .charge_ctrl(ctrl),
    .charge_stop(charge_stop));
  smb_host_model smb_host_model_i (.mclk(mclk), .sda_oe(sda_oe), .pins(pins));

  // ==========================================================================
  // Checking
  task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // One compare task for each kind of result
  task automatic cmp_read(input logic [15:0] got, input logic [15:0] exp);
    cmp("read", got, exp);
  endtask
  task automatic cmp_ctrl(input charge_limit_pkg::charge_ctrl_s got, input logic [18:0] exp);
    cmp("ctrl", got, exp);
  endtask
  task automatic cmp_ack(input logic got, input logic exp);
    cmp("ack", got, exp);
  endtask
  task automatic cmp_count(input int got, input int exp);
    cmp("count", got, exp);
  endtask
  // Each finished read takes the oldest note
  always @(smb_host_model_i.rd_ev) begin
    if (notes_q.size() == 0) cmp("note", 1, 0);
    else cmp_read(smb_host_model_i.rd_word, notes_q.pop_front());
  end
  always @(posedge mclk) if (charge_stop === 1'b1) stops++;
  task automatic ctl;
    logic [6:0] m;
    m = (current_limit_pin < cur) ? current_limit_pin : cur;
    @(negedge mclk);
    cmp_ctrl(ctrl, {m, volt, cur != 7'h00 && volt != 11'h000});
  endtask
  // Read back only the code field; unused bits read 0
  task automatic chk(input logic [7:0] cmd);
    notes_q.push_back(cmd[0] ? {1'b0, volt, 4'h0} : {3'h0, cur, 6'h00});
    smb_host_model_i.read_word(cmd, rd, ok);
    cmp_ack(ok, 1'b1);
    ctl;
  endtask
  // Out-of-range words clear the register and stop charging
  task automatic put(input logic [7:0] cmd, input logic [15:0] d);
    smb_host_model_i.write_word(cmd, d, ok);
    cmp_ack(ok, 1'b1);
    if (cmd == charge_limit_pkg::CMD_CHARGE_CURRENT) begin
      cur = (d[12:6] >= charge_limit_pkg::CUR_CODE_MIN) ? d[12:6] : 7'h00;
      exp_stops += (cur == 7'h00);
    end else begin
      volt = (d[14:4] inside {[charge_limit_pkg::VOLT_CODE_MIN:charge_limit_pkg::VOLT_CODE_MAX]}) ?
        d[14:4] : 11'h000;
      exp_stops += (volt == 11'h000);
    end
    chk(cmd);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    chk(charge_limit_pkg::CMD_CHARGE_CURRENT);
    chk(charge_limit_pkg::CMD_CHARGE_VOLTAGE);
    $display("test reset done");
    foreach (VEC[i]) put(VEC[i][23:16], VEC[i][15:0]);
    $display("test ranges done");
    // Unknown command and a foreign address are both refused and change nothing
    smb_host_model_i.write_word(8'h16, 16'hFFFF, ok);
    cmp_ack(ok, 1'b0);
    smb_host_model_i.addr_r = charge_limit_pkg::DEV_ADDR_DEFAULT ^ 7'h01;
    smb_host_model_i.write_word(charge_limit_pkg::CMD_CHARGE_CURRENT, 16'h0080, ok);
    smb_host_model_i.addr_r = charge_limit_pkg::DEV_ADDR_DEFAULT;
    cmp_ack(ok, 1'b0);
    chk(charge_limit_pkg::CMD_CHARGE_CURRENT);
    $display("test command done");
    // Nonzero pin keeps enable tied to the register codes alone
    for (int i = 0; i < 6; i++) begin
      current_limit_pin = 7'($random(seed)) | 7'h01;
      ctl;
      put(charge_limit_pkg::CMD_CHARGE_CURRENT, 16'($random(seed)));
    end
    $display("test pin done");
    cmp_count(stops, exp_stops);
    // A second reset must drop both settings to zero whatever was written
    resetn = 1'b0;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    cur = 7'h00;
    volt = 11'h000;
    chk(charge_limit_pkg::CMD_CHARGE_CURRENT);
    chk(charge_limit_pkg::CMD_CHARGE_VOLTAGE);
    $display("test second reset done");
    final_report;
  end
  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (95000) @(posedge mclk);
    err_count++;
    final_report;
  end
endmodule
